// ### design/wdt_counter.sv
`include "wdt_regs.svh"
`default_nettype none
module wdt_counter (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Control side
    wdt_cnt_if.cnt    cif
);

    wdt_pkg::wdt_cnt_state_t s_reg;
    wdt_pkg::wdt_cnt_state_t s_next;
    logic                    rise;
    logic                    ev;

    always_comb begin
        s_next = s_reg;
        rise = cif.enable & ~s_reg.en_d;
        ev = 1'b0;
        s_next.en_d = cif.enable;
        if (rise) begin
            s_next.pend = 1'b1;
        end
        if (cif.tick && cif.enable && !s_reg.stopped) begin
            if (s_reg.pend || rise) begin
                s_next.count = cif.reload;
                s_next.pend = 1'b0;
            end else if (s_reg.count == '0) begin
                ev = 1'b1;
                s_next.count = cif.reload;
                s_next.raw = 1'b1;
                if (s_reg.raw && !cif.clear && cif.res_en) begin
                    s_next.req = 1'b1;
                    s_next.stopped = 1'b1;
                end
            end else begin
                s_next.count = s_reg.count - 32'h1;
            end
        end
        if (cif.load || cif.clear) begin
            s_next.count = cif.reload;
        end
        if (cif.clear && !ev) begin
            s_next.raw = 1'b0;
        end
        if (cif.cnt_rst) begin
            s_next = '0;
            s_next.count = `WDT_COUNT_RST;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '0;
            s_reg.count <= `WDT_COUNT_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cif.count = s_reg.count;
    assign cif.raw = s_reg.raw;
    assign cif.raw_nxt = s_next.raw;
    assign cif.req_nxt = s_next.req;

    timeout_raise_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.tick && cif.enable && !s_reg.stopped && !s_reg.pend && !rise
            && s_reg.count == '0 && !cif.cnt_rst |=> s_reg.raw)
        else $error("timeout did not raise interrupt");

    stop_after_req_a: assert property (@(posedge i_clk) disable iff (i_rst)
        s_reg.stopped && !cif.load && !cif.clear && !cif.cnt_rst
            |=> $stable(s_reg.count))
        else $error("counter moved after reset request");

endmodule
`default_nettype wire

// ### design/wdt_top.sv
`include "wdt_regs.svh"
`default_nettype none
module wdt_top (
    // Clock and bus reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Register port
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:2] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output var  logic [31:0] o_prdata,
    // Counting clock pins
    input  wire logic        i_count_clock,
    input  wire logic        i_count_clock_enable,
    input  wire logic        i_count_domain_reset_n,
    // Event outputs
    output var  logic        o_timeout_irq,
    output var  logic        o_system_reset_request
);

    wdt_pkg::wdt_bus_state_t s_reg;
    wdt_pkg::wdt_bus_state_t s_next;
    logic                    wr_acc;
    logic                    rd_setup;
    logic                    wr_ok;
    logic [31:0]             rd_val;

    wdt_cnt_if cif ();

    function automatic logic hit(input logic [11:2] addr, input logic [11:0] ofs);
        hit = ({addr, 2'b00} == ofs);
    endfunction

    always_comb begin
        rd_val = 32'h0;
        if (hit(i_paddr, `WDT_RELOAD_OFS)) begin
            rd_val = s_reg.reload;
        end else if (hit(i_paddr, `WDT_COUNT_OFS)) begin
            rd_val = cif.count;
        end else if (hit(i_paddr, `WDT_CONTROL_OFS)) begin
            rd_val = {30'h0, s_reg.ctrl};
        end else if (hit(i_paddr, `WDT_RAW_OFS)) begin
            rd_val = {31'h0, cif.raw};
        end else if (hit(i_paddr, `WDT_MASKED_OFS)) begin
            rd_val = {31'h0, cif.raw & s_reg.ctrl[`WDT_CTRL_EN_BIT]};
        end else if (hit(i_paddr, `WDT_LOCK_OFS)) begin
            rd_val = {31'h0, s_reg.locked};
        end
    end

    always_comb begin
        s_next = s_reg;
        wr_acc = i_psel & i_penable & i_pwrite;
        rd_setup = i_psel & ~i_penable & ~i_pwrite;
        wr_ok = wr_acc & ~s_reg.locked;

        s_next.cc_s1 = i_count_clock;
        s_next.cc_s2 = s_reg.cc_s1;
        s_next.cc_d = s_reg.cc_s2;
        s_next.ce_s1 = i_count_clock_enable;
        s_next.ce_s2 = s_reg.ce_s1;
        s_next.rn_s1 = i_count_domain_reset_n;
        s_next.rn_s2 = s_reg.rn_s1;

        if (rd_setup) begin
            s_next.prdata = rd_val;
        end

        if (wr_acc && hit(i_paddr, `WDT_LOCK_OFS)) begin
            s_next.locked = (i_pwdata != `WDT_UNLOCK_KEY);
        end
        if (wr_ok && hit(i_paddr, `WDT_RELOAD_OFS)) begin
            s_next.reload = i_pwdata;
        end
        if (wr_ok && hit(i_paddr, `WDT_CONTROL_OFS)) begin
            s_next.ctrl = i_pwdata[1:0];
        end

        s_next.irq = cif.raw_nxt & s_next.ctrl[`WDT_CTRL_EN_BIT];
        s_next.rstreq = cif.req_nxt & s_next.ctrl[`WDT_CTRL_RES_BIT];
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '0;
            s_reg.reload <= `WDT_RELOAD_RST;
            s_reg.ctrl <= `WDT_CONTROL_RST;
            s_reg.locked <= `WDT_LOCKED_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cif.tick = s_reg.cc_s2 & ~s_reg.cc_d & s_reg.ce_s2;
    assign cif.cnt_rst = ~s_reg.rn_s2;
    assign cif.enable = s_reg.ctrl[`WDT_CTRL_EN_BIT];
    assign cif.res_en = s_reg.ctrl[`WDT_CTRL_RES_BIT];
    assign cif.load = wr_ok & hit(i_paddr, `WDT_RELOAD_OFS);
    assign cif.clear = wr_ok & hit(i_paddr, `WDT_CLEAR_OFS);
    assign cif.reload = s_next.reload;

    wdt_counter u_counter (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .cif   (cif.cnt)
    );

    assign o_prdata = s_reg.prdata;
    assign o_timeout_irq = s_reg.irq;
    assign o_system_reset_request = s_reg.rstreq;

    irq_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_timeout_irq == (cif.raw & s_reg.ctrl[`WDT_CTRL_EN_BIT]))
        else $error("interrupt output differs from masked status");

    reset_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !s_reg.ctrl[`WDT_CTRL_RES_BIT] |-> !o_system_reset_request)
        else $error("reset request while masked");

    lock_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_acc && hit(i_paddr, `WDT_LOCK_OFS)
            |=> s_reg.locked == ($past(i_pwdata) != `WDT_UNLOCK_KEY))
        else $error("lock state not updated");

    lock_block_a: assert property (@(posedge i_clk) disable iff (i_rst)
        s_reg.locked && wr_acc && !hit(i_paddr, `WDT_LOCK_OFS)
            |=> $stable(s_reg.reload) && $stable(s_reg.ctrl))
        else $error("write passed while locked");

    lock_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_setup && hit(i_paddr, `WDT_LOCK_OFS)
            |=> o_prdata == {31'h0, $past(s_reg.locked)})
        else $error("lock read wrong");

    unmapped_rd_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_setup && ({i_paddr, 2'b00} > `WDT_MASKED_OFS)
            && !hit(i_paddr, `WDT_LOCK_OFS) |=> o_prdata == 32'h0)
        else $error("unmapped read not zero");

    clear_irq_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.clear && !cif.tick |=> !o_timeout_irq)
        else $error("interrupt not cleared at once");

    load_now_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.load && !cif.cnt_rst |=> cif.count == $past(i_pwdata))
        else $error("reload write did not reload counter");

    count_freeze_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !cif.enable && !cif.load && !cif.clear && !cif.cnt_rst
            |=> $stable(cif.count))
        else $error("counter moved while disabled");

    idle_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !cif.tick && !cif.load && !cif.clear && !cif.cnt_rst
            |=> $stable(cif.count))
        else $error("counter moved without enabled edge");

    // Register writes: only an accepted, unlocked write moves reload or control; any accepted lock write moves the lock
    reload_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ok && hit(i_paddr, `WDT_RELOAD_OFS)
            |=> s_reg.reload == $past(i_pwdata))
        else $error("reload write not taken");

    reload_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_ok && hit(i_paddr, `WDT_RELOAD_OFS))
            |=> $stable(s_reg.reload))
        else $error("reload changed without write");

    ctrl_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_ok && hit(i_paddr, `WDT_CONTROL_OFS)
            |=> {30'h0, s_reg.ctrl} == ($past(i_pwdata) & 32'h3))
        else $error("control write not taken");

    ctrl_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_ok && hit(i_paddr, `WDT_CONTROL_OFS))
            |=> $stable(s_reg.ctrl))
        else $error("control changed without write");

    lock_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !(wr_acc && hit(i_paddr, `WDT_LOCK_OFS))
            |=> $stable(s_reg.locked))
        else $error("lock changed without write");

    lock_no_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
        s_reg.locked
            |-> !cif.load && !cif.clear)
        else $error("reload or clear passed while locked");

    // Read data is captured at the setup edge and stands from the next edge
    reload_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_setup && hit(i_paddr, `WDT_RELOAD_OFS)
            |=> o_prdata == $past(s_reg.reload))
        else $error("reload read wrong");

    count_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_setup && hit(i_paddr, `WDT_COUNT_OFS)
            |=> o_prdata == $past(cif.count))
        else $error("count read not live");

    ctrl_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_setup && hit(i_paddr, `WDT_CONTROL_OFS)
            |=> o_prdata == {30'h0, $past(s_reg.ctrl)})
        else $error("control read wrong");

    raw_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_setup && hit(i_paddr, `WDT_RAW_OFS)
            |=> o_prdata == {31'h0, $past(cif.raw)})
        else $error("raw status read wrong");

    masked_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_setup && hit(i_paddr, `WDT_MASKED_OFS)
            |=> o_prdata == {31'h0, $past(o_timeout_irq)})
        else $error("masked status differs from interrupt pin");

    clear_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_setup && hit(i_paddr, `WDT_CLEAR_OFS)
            |=> o_prdata == 32'h0)
        else $error("write-only location read not zero");

    // Interrupt and reset request rise only from an enabled counting edge or a control write that unmasks them
    clear_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.clear && !cif.cnt_rst
            |=> cif.count == $past(s_reg.reload))
        else $error("clear did not reload counter");

    clear_raw_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.clear && !cif.tick
            |=> !cif.raw)
        else $error("clear did not drop raw status");

    load_keeps_raw_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.load && cif.raw && !cif.cnt_rst
            |=> cif.raw)
        else $error("reload write dropped pending interrupt");

    raw_needs_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !cif.tick && !cif.raw
            |=> !cif.raw)
        else $error("raw status rose without counting edge");

    irq_needs_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !cif.tick && !(wr_ok && hit(i_paddr, `WDT_CONTROL_OFS))
            && !o_timeout_irq
            |=> !o_timeout_irq)
        else $error("interrupt rose without counting edge");

    irq_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !s_reg.ctrl[`WDT_CTRL_EN_BIT]
            |-> !o_timeout_irq)
        else $error("interrupt while disabled");

    req_needs_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !cif.tick && !(wr_ok && hit(i_paddr, `WDT_CONTROL_OFS))
            && !o_system_reset_request
            |=> !o_system_reset_request)
        else $error("reset request rose without counting edge");

    req_sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_system_reset_request && !cif.cnt_rst
            && !(wr_ok && hit(i_paddr, `WDT_CONTROL_OFS))
            |=> o_system_reset_request)
        else $error("reset request dropped on its own");

    // Counting domain: reset, pin sync and count steps
    cnt_rst_count_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.cnt_rst
            |=> cif.count == `WDT_COUNT_RST && !cif.raw)
        else $error("counting reset left state behind");

    cnt_rst_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.cnt_rst
            |=> !o_system_reset_request && !o_timeout_irq)
        else $error("outputs high after counting reset");

    count_rst_sync_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !s_reg.rn_s1
            |=> cif.cnt_rst)
        else $error("counting reset lost in synchroniser");

    tick_once_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.tick
            |=> !cif.tick)
        else $error("one counting edge seen twice");

    gate_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !s_reg.ce_s2
            |-> !cif.tick)
        else $error("counting edge passed while gated");

    zero_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.tick && cif.enable && cif.count == 32'h0
            && !cif.load && !cif.clear && !cif.cnt_rst
            |=> cif.count == $past(s_reg.reload))
        else $error("zero count not reloaded");

    count_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
        cif.tick && cif.enable && cif.count != 32'h0
            && !cif.load && !cif.clear && !cif.cnt_rst
            |=> cif.count == $past(cif.count) - 32'h1 || cif.count == $past(s_reg.reload))
        else $error("counter step not one or reload");

endmodule
`default_nettype wire

// ### inc/wdt_cnt_if.sv
`default_nettype none
interface wdt_cnt_if;
    logic        tick;
    logic        cnt_rst;
    logic        enable;
    logic        res_en;
    logic        load;
    logic        clear;
    logic [31:0] reload;
    logic [31:0] count;
    logic        raw;
    logic        raw_nxt;
    logic        req_nxt;

    modport ctl (output tick, cnt_rst, enable, res_en, load, clear, reload,
                 input  count, raw, raw_nxt, req_nxt);
    modport cnt (input  tick, cnt_rst, enable, res_en, load, clear, reload,
                 output count, raw, raw_nxt, req_nxt);
endinterface
`default_nettype wire

// ### inc/wdt_pkg.sv
`default_nettype none
package wdt_pkg;

    localparam int CNT_W = 32;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             raw;
        logic             req;
        logic             stopped;
        logic             en_d;
        logic             pend;
    } wdt_cnt_state_t;

    typedef struct packed {
        logic             cc_s1;
        logic             cc_s2;
        logic             cc_d;
        logic             ce_s1;
        logic             ce_s2;
        logic             rn_s1;
        logic             rn_s2;
        logic [CNT_W-1:0] reload;
        logic [1:0]       ctrl;
        logic             locked;
        logic [31:0]      prdata;
        logic             irq;
        logic             rstreq;
    } wdt_bus_state_t;

endpackage
`default_nettype wire

// ### inc/wdt_regs.svh
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// Register byte offsets
`define WDT_RELOAD_OFS    12'h000
`define WDT_COUNT_OFS     12'h004
`define WDT_CONTROL_OFS   12'h008
`define WDT_CLEAR_OFS     12'h00c
`define WDT_RAW_OFS       12'h010
`define WDT_MASKED_OFS    12'h014
`define WDT_LOCK_OFS      12'hc00

// Control fields
`define WDT_CTRL_EN_BIT   0
`define WDT_CTRL_RES_BIT  1

// Reset values and key
`define WDT_RELOAD_RST    32'hffffffff
`define WDT_COUNT_RST     32'hffffffff
`define WDT_CONTROL_RST   2'h0
`define WDT_LOCKED_RST    1'b0
`define WDT_UNLOCK_KEY    32'h1acce551

`endif

// ### tb/wdt_cnt_src.sv
`default_nettype none
module wdt_cnt_src (
    // Bus clock and run request
    input  wire logic i_clk,
    input  wire logic i_run,
    // Counting clock
    output var  logic o_count_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_reg;
    always_ff @(posedge i_clk) begin
        if (!i_run) begin
            div_reg       <= 3'h0;
            o_count_clock <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            if (div_reg == 3'h7) begin
                o_count_clock <= !o_count_clock;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/wdt_top_tb.sv
`include "wdt_regs.svh"
`default_nettype none
module wdt_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk, i_rst, psel, pen, pwr, run, gate, crst_n, irq, sreq, cclk;
    logic [11:2] paddr;
    logic [31:0] pwdata, prdata, rdata, keep;
    int          n_errors, cmp_count;

    wdt_cnt_src u_src (.i_clk(i_clk), .i_run(run), .o_count_clock(cclk));
    wdt_top u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .i_count_clock(cclk), .i_count_clock_enable(gate),
        .i_count_domain_reset_n(crst_n), .o_timeout_irq(irq),
        .o_system_reset_request(sreq)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel   <= 1'b1;
        pwr    <= 1'b1;
        paddr  <= a[11:2];
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        @(posedge i_clk);
        psel <= 1'b0;
        pen  <= 1'b0;
        #1;
    endtask

    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        @(posedge i_clk);
        psel  <= 1'b1;
        pwr   <= 1'b0;
        paddr <= a[11:2];
        @(posedge i_clk);
        pen <= 1'b1;
        @(posedge i_clk);
        rdata = prdata;
        psel <= 1'b0;
        pen  <= 1'b0;
        #1;
        chk(nm, rdata, e);
    endtask

    // Counting clock runs only inside this window
    task automatic edges(input int n);
        int   k;
        int   t;
        logic prev;
        k = 0;
        t = 0;
        @(posedge i_clk);
        run <= 1'b1;
        while (k < n) begin
            prev = cclk;
            @(posedge i_clk);
            #1;
            t++;
            if (cclk && !prev) begin
                k++;
            end
            if (t > 400) begin
                n_errors++;
                end_of_test();
            end
        end
        repeat (4) @(posedge i_clk);
        run <= 1'b0;
        #1;
    endtask

    initial begin
        i_rst     = 1'b1;
        crst_n    = 1'b0;
        psel      = 1'b0;
        pen       = 1'b0;
        pwr       = 1'b0;
        paddr     = '0;
        pwdata    = '0;
        run       = 1'b0;
        gate      = 1'b1;
        n_errors  = 0;
        cmp_count = 0;
        repeat (2) @(posedge i_clk);
        i_rst  <= 1'b0;
        crst_n <= 1'b1;
        rc("reload", 12'h000, 32'hffffffff);
        rc("count", 12'h004, 32'hffffffff);
        rc("control", 12'h008, 32'h0);
        rc("lock", 12'hc00, 32'h0);
        rc("raw", 12'h010, 32'h0);
        rc("unmapped", 12'h018, 32'h0);
        edges(2);
        rc("count", 12'h004, 32'hffffffff);
        wr(12'h000, 32'h5);
        rc("count", 12'h004, 32'h5);
        wr(12'h008, 32'h3);
        edges(3);
        rc("count", 12'h004, 32'h3);
        @(posedge i_clk);
        gate <= 1'b0;
        edges(2);
        rc("count", 12'h004, 32'h3);
        @(posedge i_clk);
        gate <= 1'b1;
        edges(3);
        chk("irq", irq, 32'h0);
        edges(1);
        chk("irq", irq, 32'h1);
        rc("count", 12'h004, 32'h5);
        rc("masked", 12'h014, 32'h1);
        edges(2);
        wr(12'h00c, 32'h0);
        rc("count", 12'h004, 32'h5);
        chk("irq", irq, 32'h0);
        edges(6);
        chk("irq", irq, 32'h1);
        edges(2);
        wr(12'h008, 32'h2);
        rc("masked", 12'h014, 32'h0);
        chk("irq", irq, 32'h0);
        rc("raw", 12'h010, 32'h1);
        edges(2);
        rc("count", 12'h004, 32'h3);
        wr(12'h008, 32'h1);
        edges(1);
        rc("count", 12'h004, 32'h5);
        edges(6);
        chk("sreq", sreq, 32'h0);
        rc("count", 12'h004, 32'h5);
        wr(12'h008, 32'h3);
        edges(6);
        chk("sreq", sreq, 32'h1);
        rc("count", 12'h004, 32'h5);
        keep = rdata;
        edges(2);
        rc("count", 12'h004, keep);
        @(posedge i_clk);
        crst_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        crst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1;
        chk("sreq", sreq, 32'h0);
        rc("count", 12'h004, 32'hffffffff);
        wr(12'hc00, 32'h0);
        rc("lock", 12'hc00, 32'h1);
        wr(12'h000, 32'h9);
        rc("reload", 12'h000, 32'h5);
        wr(12'hc00, `WDT_UNLOCK_KEY);
        rc("lock", 12'hc00, 32'h0);
        wr(12'h008, 32'h0);
        wr(12'h000, 32'h0);
        wr(12'h008, 32'h3);
        edges(1);
        chk("irq", irq, 32'h0);
        edges(1);
        chk("irq", irq, 32'h1);
        wr(12'h000, 32'h7);
        rc("count", 12'h004, 32'h7);
        chk("irq", irq, 32'h1);
        edges(1);
        rc("count", 12'h004, 32'h6);
        rc("count", 12'h004, 32'h6);
        @(posedge i_clk);
        i_rst <= 1'b1;
        @(posedge i_clk);
        i_rst <= 1'b0;
        rc("control", 12'h008, 32'h0);
        chk("irq", irq, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
